// ---- src/jsad_regs.sv ----
// Operation
// - jack presence read-only at bits 7-6
// - headset type read-only at bits 5-4
// - policy 0: ADC power by software only
// - policy 1: activity powers ADC up and down
// - policy 2: activity powers up, software down
// - monitor channel bits 5-4, reset channel 3
// - bit 3 routes irq to data-out pin
// - bit 1 keeps detection alive while recording
// - tone generation channel bits 7-6, reset 3
// - status updates only when detection enabled
`timescale 1ns/10ps
module jsad_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control interface register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// jack detection front end
	input wire logic headset_detect_enable,
	input wire logic debounce_done,
	input wire logic [1:0] jack_kind_in,
	input wire logic [1:0] headset_kind_code_in,
	// activity detector and recording state
	input wire logic activity_event,
	input wire logic quiet_event,
	input wire logic recording,
	input wire logic sw_power_up,
	input wire logic sw_power_down,
	// steering outputs
	output logic adc_power_on,
	output logic detect_active,
	output logic [3:0] monitor_channel_onehot,
	output logic [3:0] tone_channel_onehot,
	output logic serial_data_out_irq_oe,
	output logic serial_data_out_irq
);
	logic [1:0] jack_kind_r;
	logic [1:0] headset_kind_code_r;
	logic [7:0] act_cfg_r;
	logic [7:0] sig_cfg_r;
	logic adc_on_r;
	logic irq_r;
	logic [1:0] auto_power_policy;
	logic [1:0] monitor_channel_select;
	logic [1:0] tone_gen_channel_select;
	logic dataout_irq_enable;
	logic detect_while_recording;
	logic det_evt;
	logic quiet_evt;

	// channel code n selects channel n+1, as a one-hot lane enable
	function automatic logic [3:0] ch_onehot(input logic [1:0] code);
		ch_onehot = 4'h1 << code;
	endfunction : ch_onehot

	assign auto_power_policy = act_cfg_r[jsad_pkg::POLICY_LSB +: 2];
	assign monitor_channel_select = act_cfg_r[jsad_pkg::MON_CH_LSB +: 2];
	assign dataout_irq_enable = act_cfg_r[jsad_pkg::DOUT_IRQ_BIT];
	assign detect_while_recording = act_cfg_r[jsad_pkg::DET_REC_BIT];
	assign tone_gen_channel_select = sig_cfg_r[jsad_pkg::TONE_CH_LSB +: 2];

	// status capture; gated so a bouncing comparator never reaches software
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			jack_kind_r <= jsad_pkg::JACK_STATUS_RST[7:6];
			headset_kind_code_r <= jsad_pkg::JACK_STATUS_RST[5:4];
		end else if (headset_detect_enable && debounce_done) begin
			jack_kind_r <= jack_kind_in;
			headset_kind_code_r <= headset_kind_code_in;
		end
	end

	// configuration writes; reserved bits are masked off so they read zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			act_cfg_r <= jsad_pkg::ACT_DET_CFG_RST;
			sig_cfg_r <= jsad_pkg::SIG_GEN_CFG_RST;
		end else if (reg_wr) begin
			if (reg_addr == jsad_pkg::ACT_DET_CFG_OFS)
				act_cfg_r <= reg_wdata & jsad_pkg::ACT_DET_CFG_WMASK;
			if (reg_addr == jsad_pkg::SIG_GEN_CFG_OFS)
				sig_cfg_r <= reg_wdata & jsad_pkg::SIG_GEN_CFG_WMASK;
		end
	end

	// read mux; reading changes no state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				jsad_pkg::JACK_STATUS_OFS: reg_rdata <= {jack_kind_r, headset_kind_code_r, 4'h0};
				jsad_pkg::ACT_DET_CFG_OFS: reg_rdata <= act_cfg_r;
				jsad_pkg::SIG_GEN_CFG_OFS: reg_rdata <= sig_cfg_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// jack status is read-only: writes to it are accepted and dropped
	assign reg_hit = (reg_addr == jsad_pkg::JACK_STATUS_OFS) ||
		(reg_addr == jsad_pkg::ACT_DET_CFG_OFS) || (reg_addr == jsad_pkg::SIG_GEN_CFG_OFS);

	// detector runs while idle, or while recording only if allowed
	assign detect_active = !recording || detect_while_recording;
	assign det_evt = activity_event && detect_active;
	assign quiet_evt = quiet_event && detect_active;
	assign monitor_channel_onehot = ch_onehot(monitor_channel_select);
	assign tone_channel_onehot = ch_onehot(tone_gen_channel_select);

	// adc power policy; software request wins over an event in the same cycle
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			adc_on_r <= 1'b0;
		end else if (sw_power_down) begin
			adc_on_r <= 1'b0;
		end else if (sw_power_up) begin
			adc_on_r <= 1'b1;
		end else begin
			unique case (auto_power_policy)
				jsad_pkg::JSAD_POL_USER: adc_on_r <= adc_on_r;
				jsad_pkg::JSAD_POL_AUTO_BOTH: begin
					if (det_evt)
						adc_on_r <= 1'b1;
					else if (quiet_evt)
						adc_on_r <= 1'b0;
				end
				jsad_pkg::JSAD_POL_AUTO_UP: begin
					if (det_evt)
						adc_on_r <= 1'b1;
				end
				default: adc_on_r <= adc_on_r; // reserved code behaves as user mode
			endcase
		end
	end
	assign adc_power_on = adc_on_r;

	// interrupt pulse on data-out, only while no channel data is recorded
	always_ff @(posedge clk) begin
		if (!reset_n)
			irq_r <= 1'b0;
		else
			irq_r <= det_evt && dataout_irq_enable && !recording;
	end
	assign serial_data_out_irq = irq_r;
	assign serial_data_out_irq_oe = dataout_irq_enable && !recording;

	// checks; bus steps and quiet software requests are shared sequences
	sequence s_sw_quiet;
		!sw_power_up && !sw_power_down;
	endsequence

	// a status read presented on the bus
	sequence s_status_read;
		reg_rd && reg_addr == jsad_pkg::JACK_STATUS_OFS;
	endsequence

	// a read of the activity detection configuration
	sequence s_cfg_read;
		reg_rd && reg_addr == jsad_pkg::ACT_DET_CFG_OFS;
	endsequence

	// writes of the two configuration registers
	sequence s_act_write;
		reg_wr && reg_addr == jsad_pkg::ACT_DET_CFG_OFS;
	endsequence
	sequence s_sig_write;
		reg_wr && reg_addr == jsad_pkg::SIG_GEN_CFG_OFS;
	endsequence

	AST_USER_HOLDS: assert property (@(posedge clk) disable iff (!reset_n)
		((auto_power_policy == 2'h0) and s_sw_quiet) |=> $stable(adc_on_r))
		else $error("adc power changed without request in user mode");
	AST_AUTO_UP: assert property (@(posedge clk) disable iff (!reset_n)
		(auto_power_policy == 2'h1) && det_evt && !sw_power_down |=> adc_on_r)
		else $error("activity did not power adc up");
	AST_AUTO_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
		(((auto_power_policy == 2'h1) && quiet_evt && !det_evt) and s_sw_quiet) |=> !adc_on_r)
		else $error("quiet did not power adc down");
	AST_UP_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
		(auto_power_policy == 2'h2) && adc_on_r && !sw_power_down |=> adc_on_r)
		else $error("adc powered down automatically in up-only mode");
	AST_STATUS_FROZEN: assert property (@(posedge clk) disable iff (!reset_n)
		!headset_detect_enable |=> $stable(jack_kind_r) && $stable(headset_kind_code_r))
		else $error("status changed while detection disabled");
	AST_STATUS_RSVD: assert property (@(posedge clk) disable iff (!reset_n)
		$past(reg_rd) && $past(reg_addr) == jsad_pkg::JACK_STATUS_OFS |-> reg_rdata[3:0] == 4'h0)
		else $error("reserved status bits not zero");
	AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!reset_n)
		irq_r |-> $past(dataout_irq_enable) && !$past(recording))
		else $error("data-out irq without enable or during recording");
	AST_REC_DETECT: assert property (@(posedge clk) disable iff (!reset_n)
		recording && !detect_while_recording |-> !detect_active)
		else $error("detector active while recording");
	AST_MON_CH: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(reset_n) |-> monitor_channel_onehot == 4'h4)
		else $error("monitor channel not 3 after reset");
	AST_TONE_CH: assert property (@(posedge clk) disable iff (!reset_n)
		tone_channel_onehot == (4'h1 << sig_cfg_r[7:6]))
		else $error("tone channel does not follow field");

	// read data shows the captured status with the reserved nibble clear
	AST_RD_STATUS: assert property (@(posedge clk) disable iff (!reset_n)
		s_status_read |=> reg_rdata == {$past(jack_kind_r), $past(headset_kind_code_r), 4'h0})
		else $error("status read data wrong");

	// configuration read returns the stored register
	AST_RD_CFG: assert property (@(posedge clk) disable iff (!reset_n)
		s_cfg_read |=> reg_rdata == $past(act_cfg_r))
		else $error("configuration read data wrong");

	// a configuration write lands with its reserved bits cleared
	AST_WR_ACT: assert property (@(posedge clk) disable iff (!reset_n)
		s_act_write |=> act_cfg_r == ($past(reg_wdata) & jsad_pkg::ACT_DET_CFG_WMASK))
		else $error("activity configuration write lost");

	// the tone channel write lands the same way
	AST_WR_SIG: assert property (@(posedge clk) disable iff (!reset_n)
		s_sig_write |=> sig_cfg_r == ($past(reg_wdata) & jsad_pkg::SIG_GEN_CFG_WMASK))
		else $error("signal generation write lost");

	// read data stands until the next read
	AST_RD_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	// a read alone leaves both configuration registers as they were
	AST_RD_SIDE_FREE: assert property (@(posedge clk) disable iff (!reset_n)
		reg_rd && !reg_wr |=> $stable(act_cfg_r) && $stable(sig_cfg_r))
		else $error("read changed configuration");

	// the status register ignores writes
	AST_RO_STATUS: assert property (@(posedge clk) disable iff (!reset_n)
		reg_wr && reg_addr == jsad_pkg::JACK_STATUS_OFS && !debounce_done |=>
		$stable(jack_kind_r) && $stable(headset_kind_code_r))
		else $error("write reached the status register");

	// reserved configuration bits never hold a one
	AST_CFG_RSVD: assert property (@(posedge clk) disable iff (!reset_n)
		(act_cfg_r & ~jsad_pkg::ACT_DET_CFG_WMASK) == 8'h00 &&
		(sig_cfg_r & ~jsad_pkg::SIG_GEN_CFG_WMASK) == 8'h00)
		else $error("reserved configuration bit set");

	// status holds between debounced samples, so a bounce never shows
	AST_NO_DEBOUNCE: assert property (@(posedge clk) disable iff (!reset_n)
		!debounce_done |=> $stable(jack_kind_r) && $stable(headset_kind_code_r))
		else $error("status changed without debounce");

	// an enabled, debounced sample is what software reads next
	AST_STATUS_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)
		headset_detect_enable && debounce_done |=>
		jack_kind_r == $past(jack_kind_in) &&
		headset_kind_code_r == $past(headset_kind_code_in))
		else $error("debounced status not captured");

	// a software power-down always wins
	AST_SW_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
		sw_power_down |=> !adc_on_r)
		else $error("software power-down ignored");

	// a software power-up works in every policy
	AST_SW_UP: assert property (@(posedge clk) disable iff (!reset_n)
		sw_power_up && !sw_power_down |=> adc_on_r)
		else $error("software power-up ignored");

	// the unused policy code acts as user mode
	AST_RSVD_POLICY: assert property (@(posedge clk) disable iff (!reset_n)
		((auto_power_policy == 2'h3) and s_sw_quiet) |=> $stable(adc_on_r))
		else $error("adc power changed under the unused policy code");

	// activity powers the adc up under the up-only policy
	AST_UP_ONLY_RISE: assert property (@(posedge clk) disable iff (!reset_n)
		(auto_power_policy == 2'h2) && det_evt && !sw_power_down |=> adc_on_r)
		else $error("activity did not power adc up in up-only mode");

	// an enabled activity event reaches the data-out pin one cycle later
	AST_IRQ_FIRE: assert property (@(posedge clk) disable iff (!reset_n)
		det_evt && dataout_irq_enable && !recording |=> irq_r)
		else $error("activity irq missing on data-out");

	// the pin is released while disabled or while recording
	AST_IRQ_OE: assert property (@(posedge clk) disable iff (!reset_n)
		!dataout_irq_enable || recording |-> !serial_data_out_irq_oe)
		else $error("data-out driven for irq while not allowed");

	// with bit 1 clear, activity during recording is ignored
	AST_REC_IGNORE: assert property (@(posedge clk) disable iff (!reset_n)
		((recording && !detect_while_recording) and s_sw_quiet) |=>
		$stable(adc_on_r) && !irq_r)
		else $error("activity acted on while recording");

	// with bit 1 set, activity during recording still powers the adc
	AST_REC_LIVE: assert property (@(posedge clk) disable iff (!reset_n)
		recording && detect_while_recording && activity_event &&
		(auto_power_policy == 2'h1) && !sw_power_down |=> adc_on_r)
		else $error("activity lost while recording");

	// exactly one monitored lane, the one the field names
	AST_MON_ONEHOT: assert property (@(posedge clk) disable iff (!reset_n)
		$onehot(monitor_channel_onehot) && monitor_channel_onehot[monitor_channel_select])
		else $error("monitor channel lane wrong");

	// exactly one tone lane, the one the field names
	AST_TONE_ONEHOT: assert property (@(posedge clk) disable iff (!reset_n)
		$onehot(tone_channel_onehot) && tone_channel_onehot[tone_gen_channel_select])
		else $error("tone channel lane wrong");
endmodule : jsad_regs

// ---- src/jsad_pkg.sv ----
package jsad_pkg;
	// register offsets on the control interface
	localparam logic [7:0] JACK_STATUS_OFS = 8'h1c;
	localparam logic [7:0] ACT_DET_CFG_OFS = 8'h1e;
	localparam logic [7:0] SIG_GEN_CFG_OFS = 8'h1f;
	// reset values
	localparam logic [7:0] JACK_STATUS_RST = 8'h00;
	localparam logic [7:0] ACT_DET_CFG_RST = 8'h20;
	localparam logic [7:0] SIG_GEN_CFG_RST = 8'h80;
	// field positions (low bit of each field)
	localparam int JACK_KIND_LSB = 6;
	localparam int HEADSET_KIND_LSB = 4;
	localparam int POLICY_LSB = 6;
	localparam int MON_CH_LSB = 4;
	localparam int DOUT_IRQ_BIT = 3;
	localparam int DET_REC_BIT = 1;
	localparam int TONE_CH_LSB = 6;
	// writable bits of each configuration register
	localparam logic [7:0] ACT_DET_CFG_WMASK = 8'hfa;
	localparam logic [7:0] SIG_GEN_CFG_WMASK = 8'hc0;
	// auto power policy codes
	typedef enum logic [1:0] {
		JSAD_POL_USER = 2'h0,
		JSAD_POL_AUTO_BOTH = 2'h1,
		JSAD_POL_AUTO_UP = 2'h2,
		JSAD_POL_RSVD = 2'h3
	} jsad_policy_t;
	// jack presence codes
	localparam logic [1:0] JACK_NONE = 2'h0;
	localparam logic [1:0] JACK_NO_MIC = 2'h1;
	localparam logic [1:0] JACK_RSVD = 2'h2;
	localparam logic [1:0] JACK_WITH_MIC = 2'h3;
endpackage : jsad_pkg

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, recording = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, w, st = 8'h00;
	logic reg_hit, adc_power_on, detect_active, serial_data_out_irq_oe, serial_data_out_irq;
	logic headset_detect_enable = 1'b0, debounce_done = 1'b0;
	logic [1:0] jack_kind_in = 2'h0, headset_kind_code_in = 2'h0;
	logic activity_event = 1'b0, quiet_event = 1'b0, sw_power_up = 1'b0, sw_power_down = 1'b0;
	logic [3:0] monitor_channel_onehot, tone_channel_onehot;
	int fails = 0;
	int num_checks = 0;
	logic [3:0] v = 4'h0;
	logic a_exp = 1'b0;
	jsad_regs dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.headset_detect_enable(headset_detect_enable), .debounce_done(debounce_done),
		.jack_kind_in(jack_kind_in), .headset_kind_code_in(headset_kind_code_in),
		.activity_event(activity_event), .quiet_event(quiet_event), .recording(recording),
		.sw_power_up(sw_power_up), .sw_power_down(sw_power_down), .adc_power_on(adc_power_on),
		.detect_active(detect_active), .monitor_channel_onehot(monitor_channel_onehot),
		.tone_channel_onehot(tone_channel_onehot),
		.serial_data_out_irq_oe(serial_data_out_irq_oe), .serial_data_out_irq(serial_data_out_irq));
	// free-running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		if (fails == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// channel code n names lane n+1
	function automatic logic [3:0] exp_onehot(input logic [1:0] code);
		case (code)
			2'h0: exp_onehot = 4'h1;
			2'h1: exp_onehot = 4'h2;
			2'h2: exp_onehot = 4'h4;
			default: exp_onehot = 4'h8;
		endcase
	endfunction : exp_onehot
	// adc level after one event cycle {activity, quiet, up, down}; software wins
	function automatic logic exp_adc(input logic [1:0] pol, input logic [3:0] ev_v,
		input logic live, input logic cur);
		exp_adc = cur;
		if (ev_v[0])
			exp_adc = 1'b0;
		else if (ev_v[1])
			exp_adc = 1'b1;
		else if (live && ev_v[3] && (pol == 2'h1 || pol == 2'h2))
			exp_adc = 1'b1;
		else if (live && ev_v[2] && pol == 2'h1)
			exp_adc = 1'b0;
	endfunction : exp_adc
	// one-cycle write strobe, inputs change on the falling edge only
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	// read data is registered, so it is looked at one edge after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
		chk({7'h00, reg_hit}, {7'h00, (a == 8'h1c || a == 8'h1e || a == 8'h1f)});
	endtask : rd
	// event pulse {activity, quiet, up, down}, then adc level and irq pulse
	task automatic ev(input logic [3:0] v, input logic [1:0] e);
		@(negedge clk);
		{activity_event, quiet_event, sw_power_up, sw_power_down} = v;
		@(negedge clk);
		{activity_event, quiet_event, sw_power_up, sw_power_down} = 4'h0;
		chk({7'h00, adc_power_on, serial_data_out_irq}, {6'h00, e});
	endtask : ev
	// hang guard, generous against a run of under a thousand cycles
	initial begin
		#50000;
		fails++;
		test_done();
	end
	initial begin
		void'($urandom(32'h279d));
		repeat (4) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		rd(jsad_pkg::JACK_STATUS_OFS, 8'h00);
		rd(jsad_pkg::ACT_DET_CFG_OFS, 8'h20);
		rd(jsad_pkg::SIG_GEN_CFG_OFS, 8'h80);
		rd(8'h1d, 8'h00);
		chk({monitor_channel_onehot, tone_channel_onehot}, 8'h44);
		// random config, status capture and pin steering
		for (int i = 0; i < 12; i++) begin
			w = 8'($urandom);
			// reserved bits are only ever written as zero
			wr(8'h1c, w & 8'hf0);
			wr(8'h1e, w & jsad_pkg::ACT_DET_CFG_WMASK);
			wr(8'h1f, ~w & jsad_pkg::SIG_GEN_CFG_WMASK);
			rd(8'h1e, w & jsad_pkg::ACT_DET_CFG_WMASK);
			rd(8'h1f, ~w & jsad_pkg::SIG_GEN_CFG_WMASK);
			chk({monitor_channel_onehot, tone_channel_onehot},
				{exp_onehot(w[5:4]), exp_onehot(~w[7:6])});
			headset_detect_enable = w[0];
			debounce_done = w[2];
			jack_kind_in = w[7:6];
			headset_kind_code_in = w[5:4];
			recording = w[6];
			@(negedge clk);
			debounce_done = 1'b0;
			jack_kind_in = ~jack_kind_in;
			if (w[0] && w[2]) st = {w[7:6], w[5:4], 4'h0};
			chk({6'h00, detect_active, serial_data_out_irq_oe}, {6'h00, !w[6] | w[1], w[3] & !w[6]});
			rd(8'h1c, st);
			rd(8'h1c, st);
		end
		// every power policy, with the irq pin enabled under policy 1
		recording = 1'b0;
		for (int p = 0; p < 4; p++) begin
			wr(8'h1e, {p[1:0], 2'h2, (p == 1), 3'h0});
			ev(4'h1, 2'h0);
			ev(4'h8, {(p == 1 || p == 2), (p == 1)});
			ev(4'h4, {(p == 2), 1'b0});
			ev(4'h2, 2'h2);
		end
		// detection during recording follows bit 1
		wr(8'h1e, 8'h40);
		ev(4'h1, 2'h0);
		recording = 1'b1;
		ev(4'h8, 2'h0);
		wr(8'h1e, 8'h42);
		ev(4'h8, 2'h2);
		recording = 1'b0;
		// second reset in mid-run restores defaults
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		chk({4'h0, adc_power_on, serial_data_out_irq, serial_data_out_irq_oe, detect_active},
			8'h01);
		rd(8'h1e, 8'h20);
		rd(8'h1f, 8'h80);
		rd(8'h1c, 8'h00);
		// random events and policies against the bench model; adc is off after reset
		a_exp = 1'b0;
		for (int i = 0; i < 40; i++) begin
			w = 8'($urandom);
			wr(8'h1e, w & jsad_pkg::ACT_DET_CFG_WMASK);
			recording = w[2];
			v = 4'($urandom);
			a_exp = exp_adc(w[7:6], v, !w[2] | w[1], a_exp);
			ev(v, {a_exp, v[3] & w[3] & !w[2]});
		end
		recording = 1'b0;
		test_done();
	end
endmodule : testbench
